// ==== verilog/mgmt_timing_pkg.sv ====
/*
 * constants and state types for the module management timing block.
 * assumes a 100 MHz core clock and a separate management bus clock.
 */
package mgmt_timing_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	// times in their printed units
	localparam int unsigned T_INIT_MS        = 2000;
	localparam int unsigned T_RESET_MIN_US   = 2;
	localparam int unsigned T_LP_ON_US       = 100;
	localparam int unsigned T_LP_OFF_MS      = 300;
	localparam int unsigned T_INT_ON_MS      = 200;
	localparam int unsigned T_INT_OFF_US     = 500;
	localparam int unsigned T_LOS_MS         = 100;
	localparam int unsigned T_MASK_MS        = 100;
	localparam int unsigned T_RATE_US        = 100;
	localparam int unsigned T_PDOWN_MS       = 100;
	// cycle counts; short ones fixed here, long ones top parameters
	localparam int unsigned RESET_MIN_CYC    = T_RESET_MIN_US * CLK_MHZ;
	localparam int unsigned RATE_CYC         = T_RATE_US * CLK_MHZ;
	localparam int unsigned LP_ON_CYC        = T_LP_ON_US * CLK_MHZ;
	localparam int unsigned INIT_CYC_DEF     = T_INIT_MS * CLK_MHZ * 1000;
	localparam int unsigned LP_OFF_CYC_DEF   = T_LP_OFF_MS * CLK_MHZ * 1000;
	localparam int unsigned CNT_W            = 32;
	// flag vector layout
	localparam int unsigned FLAG_W           = 8;
	localparam int unsigned FLAG_LOS         = 0;
	localparam int unsigned FLAG_TXFAULT     = 1;
	localparam int unsigned STATUS_NOT_READY = 0;
	localparam logic [7:0]  FLAGS_RESET      = 8'h00;

	typedef enum logic [1:0] {
		ST_INIT     = 2'b00,
		ST_RUN      = 2'b01,
		ST_LOWPOWER = 2'b10,
		ST_WAKE     = 2'b11
	} power_state_t;
endpackage : mgmt_timing_pkg

// ==== verilog/module_mgmt_timing.sv ====
/*
 * management and control timing of a pluggable optical module: power-up
 * and reset sequencing, bus readiness, low power by pin or control bit,
 * rate select settling, latched flags with masks and the interrupt pin.
 * assumes the bus front end on mgmt_clk reports decoded reads/writes as
 * one-cycle strobes at the stop bit; raw pins are asynchronous.
 * assumes the host spaces bus transfers a few bus clocks apart.
 */
//
// Contract
// - fully functional within init time after start
// - reset pin low past minimum pulse resets
// - management bus answers within init time
// - clear data-not-ready and interrupt within init time
// - reset release leads to functional within limit
// - low power pin high drops power fast
// - low power pin low restores function in time
// - interrupt pin goes low on any condition
// - interrupt releases soon after clear-on-read
// - receive loss sets flag and interrupt
// - transmit fault sets flag and interrupt
// - other conditions set their flags and interrupt
// - set mask stops flag driving interrupt
// - cleared mask resumes flag interrupt
// - rate select change settles bandwidth quickly
// - power-down bit set drops power level
// - power-down bit clear restores function
// - readiness shown by not-ready clear interrupt
// - read deadlines start at read stop
// - write deadlines start at write stop
`timescale 1ns/100ps
module module_mgmt_timing #(
	parameter int unsigned INIT_CYC   = mgmt_timing_pkg::INIT_CYC_DEF,
	parameter int unsigned LP_OFF_CYC = mgmt_timing_pkg::LP_OFF_CYC_DEF
) (
	// core clock and reset
	input  wire logic                               clk,
	input  wire logic                               reset_n,
	// management bus domain
	input  wire logic                               mgmt_clk,
	input  wire logic                               mgmt_read_stop,
	input  wire logic                               mgmt_write_stop,
	input  wire logic [mgmt_timing_pkg::FLAG_W-1:0] mgmt_mask_wdata,
	input  wire logic                               mgmt_pdown_wdata,
	input  wire logic                               mgmt_rate_wdata,
	output logic                                    mgmt_bus_ready,
	output logic [mgmt_timing_pkg::FLAG_W-1:0]      mgmt_flags_rdata,
	output logic                                    mgmt_not_ready_rdata,
	// module pins
	input  wire logic                               module_reset_pin_active_low,
	input  wire logic                               low_power_select_pin,
	output logic                                    interrupt_request_out_low,
	// optics side conditions
	input  wire logic                               rx_loss,
	input  wire logic                               tx_fault,
	input  wire logic [mgmt_timing_pkg::FLAG_W-1:0] other_cond,
	// power and rate controls
	output logic                                    power_level1,
	output logic                                    fully_functional,
	output logic                                    rate_select,
	output logic                                    rate_settled
);
	import mgmt_timing_pkg::*;

	// limits at counter width; the long waits are top parameters so that
	// a bench can shorten them without touching the logic
	localparam logic [CNT_W-1:0] INIT_N   = CNT_W'(INIT_CYC);
	localparam logic [CNT_W-1:0] LPOFF_N  = CNT_W'(LP_OFF_CYC);
	localparam logic [CNT_W-1:0] RSTMIN_N = CNT_W'(RESET_MIN_CYC);
	localparam logic [CNT_W-1:0] RATE_N   = CNT_W'(RATE_CYC);
	localparam logic [CNT_W-1:0] ONE      = CNT_W'(1);

	// pin and condition synchronisers; only the second flop is read
	// the reset pin stage idles high, so no false pulse follows reset
	// condition bits are independent, so they may arrive a cycle apart
	logic [1:0]        rst_pin_s;
	logic [1:0]        lp_pin_s;
	logic [1:0]        los_s;
	logic [1:0]        txf_s;
	logic [FLAG_W-1:0] oth_s0;
	logic [FLAG_W-1:0] oth_s1;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_pin_s <= 2'h3;
			lp_pin_s  <= 2'h0;
			los_s     <= 2'h0;
			txf_s     <= 2'h0;
			oth_s0    <= FLAGS_RESET;
			oth_s1    <= FLAGS_RESET;
		end else begin
			rst_pin_s <= {rst_pin_s[0], module_reset_pin_active_low};
			lp_pin_s  <= {lp_pin_s[0], low_power_select_pin};
			los_s     <= {los_s[0], rx_loss};
			txf_s     <= {txf_s[0], tx_fault};
			oth_s0    <= other_cond;
			oth_s1    <= oth_s0;
		end
	end

	// management domain: read/write stop events as toggles, write data held
	// a toggle survives the crossing where a one-cycle pulse could be lost
	// held write data stays quasi-static until the next write
	logic              rd_tog;
	logic              wr_tog;
	logic [FLAG_W-1:0] mask_m;
	logic              pdown_m;
	logic              rate_m;
	logic              next_rd_tog;
	logic              next_wr_tog;
	logic [FLAG_W-1:0] next_mask_m;
	logic              next_pdown_m;
	logic              next_rate_m;
	always_comb begin
		next_rd_tog  = rd_tog ^ mgmt_read_stop;
		next_wr_tog  = wr_tog ^ mgmt_write_stop;
		next_mask_m  = mgmt_write_stop ? mgmt_mask_wdata : mask_m;
		next_pdown_m = mgmt_write_stop ? mgmt_pdown_wdata : pdown_m;
		next_rate_m  = mgmt_write_stop ? mgmt_rate_wdata : rate_m;
	end
	always_ff @(posedge mgmt_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_tog  <= 1'b0;
			wr_tog  <= 1'b0;
			mask_m  <= FLAGS_RESET;
			pdown_m <= 1'b0;
			rate_m  <= 1'b0;
		end else begin
			rd_tog  <= next_rd_tog;
			wr_tog  <= next_wr_tog;
			mask_m  <= next_mask_m;
			pdown_m <= next_pdown_m;
			rate_m  <= next_rate_m;
		end
	end

	// core side: toggle crossing, write data taken once toggle is seen
	// the third flop only keeps the last toggle level for edge detection
	// write data is settled by then as long as transfers are spaced
	logic [2:0]        rd_s;
	logic [2:0]        wr_s;
	logic [FLAG_W-1:0] mask;
	logic              pdown;
	logic              rate_req;
	logic              rd_evt;
	logic              wr_evt;
	assign rd_evt = rd_s[2] ^ rd_s[1];
	assign wr_evt = wr_s[2] ^ wr_s[1];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_s     <= 3'h0;
			wr_s     <= 3'h0;
			mask     <= FLAGS_RESET;
			pdown    <= 1'b0;
			rate_req <= 1'b0;
		end else begin
			rd_s <= {rd_s[1:0], rd_tog};
			wr_s <= {wr_s[1:0], wr_tog};
			if (wr_evt) begin
				mask     <= mask_m;
				pdown    <= pdown_m;
				rate_req <= rate_m;
			end
		end
	end

	// reset pin pulse filter: low longer than the minimum resets
	// short glitches are ignored; the sequencer restarts on release
	// the count parks at the limit, so it cannot wrap while held low
	logic [CNT_W-1:0] rst_cnt;
	logic             pin_reset;
	logic [CNT_W-1:0] next_rst_cnt;
	logic             next_pin_reset;
	always_comb begin
		next_rst_cnt   = rst_cnt;
		next_pin_reset = pin_reset;
		if (rst_pin_s[1]) begin
			next_rst_cnt   = '0;
			next_pin_reset = 1'b0;
		end else if (rst_cnt >= RSTMIN_N) begin
			next_pin_reset = 1'b1;
		end else begin
			next_rst_cnt = rst_cnt + ONE;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_cnt   <= '0;
			pin_reset <= 1'b0;
		end else begin
			rst_cnt   <= next_rst_cnt;
			pin_reset <= next_pin_reset;
		end
	end

	// power sequencer
	// a low power request wins over the end of init; leaving low power
	// always restarts the full wake wait
	power_state_t     state;
	power_state_t     next_state;
	logic [CNT_W-1:0] pcnt;
	logic [CNT_W-1:0] next_pcnt;
	logic             not_ready;
	logic             next_not_ready;
	logic             ready_evt;
	logic             lp_req;
	assign lp_req = lp_pin_s[1] | pdown;
	always_comb begin
		next_state     = state;
		next_pcnt      = pcnt;
		next_not_ready = not_ready;
		ready_evt      = 1'b0;
		if (pin_reset) begin
			next_state     = ST_INIT;
			next_pcnt      = '0;
			next_not_ready = 1'b1;
		end else begin
			case (state)
				ST_INIT: begin
					// counted init, after pin reset too
					if (pcnt >= INIT_N - ONE) begin
						next_state     = lp_req ? ST_LOWPOWER : ST_RUN;
						next_not_ready = 1'b0;
						ready_evt      = 1'b1;
						next_pcnt      = '0;
					end else begin
						next_pcnt = pcnt + ONE;
					end
				end
				ST_RUN: begin
					if (lp_req) begin
						next_state = ST_LOWPOWER;
					end
				end
				ST_LOWPOWER: begin
					if (!lp_req) begin
						next_state = ST_WAKE;
						next_pcnt  = '0;
					end
				end
				default: begin
					if (lp_req) begin
						next_state = ST_LOWPOWER;
					end else if (pcnt >= LPOFF_N - ONE) begin
						next_state = ST_RUN;
					end else begin
						next_pcnt = pcnt + ONE;
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state     <= ST_INIT;
			pcnt      <= '0;
			not_ready <= 1'b1;
		end else begin
			state     <= next_state;
			pcnt      <= next_pcnt;
			not_ready <= next_not_ready;
		end
	end

	// rate select settling timer
	// the counter parks at its limit; any change of request restarts it
	// settled stays low for the whole settling time after a change
	logic             rate_q;
	logic [CNT_W-1:0] rate_cnt;
	logic [CNT_W-1:0] next_rate_cnt;
	always_comb begin
		next_rate_cnt = rate_cnt;
		if (rate_req != rate_q) begin
			next_rate_cnt = '0;
		end else if (rate_cnt < RATE_N - ONE) begin
			next_rate_cnt = rate_cnt + ONE;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rate_q   <= 1'b0;
			rate_cnt <= RATE_N - ONE;
		end else begin
			rate_q   <= rate_req;
			rate_cnt <= next_rate_cnt;
		end
	end

	// latched flags: set wins over clear-on-read
	// init forces flags clear so stale conditions are not reported
	logic [FLAG_W-1:0] flags;
	logic [FLAG_W-1:0] next_flags;
	logic [FLAG_W-1:0] set_v;
	logic              irq;
	logic              next_irq;
	logic              ready_irq;
	logic              next_ready_irq;
	always_comb begin
		set_v               = oth_s1;
		set_v[FLAG_LOS]     = los_s[1];
		set_v[FLAG_TXFAULT] = txf_s[1];
		next_flags = flags;
		if (rd_evt) begin
			next_flags = FLAGS_RESET;
		end
		next_flags = next_flags | set_v;
		if (state == ST_INIT) begin
			next_flags = FLAGS_RESET;
		end
		// readiness interrupt stays until a read; it is latched apart
		// from the flags so that the flag mask never hides it
		next_ready_irq = (ready_irq & ~rd_evt) | ready_evt;
		next_irq       = next_ready_irq | |(next_flags & ~mask);
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags     <= FLAGS_RESET;
			irq       <= 1'b0;
			ready_irq <= 1'b0;
		end else begin
			flags     <= next_flags;
			irq       <= next_irq;
			ready_irq <= next_ready_irq;
		end
	end

	// status and pin outputs
	// power_level1 and fully_functional follow the next state so they move with the state register
	// the interrupt pin comes from a flop so it never glitches low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_request_out_low <= 1'b1;
			power_level1              <= 1'b1;
			fully_functional          <= 1'b0;
			rate_select               <= 1'b0;
			rate_settled              <= 1'b1;
		end else begin
			interrupt_request_out_low <= ~irq;
			power_level1     <= (next_state == ST_LOWPOWER);
			fully_functional <= (next_state == ST_RUN);
			rate_select      <= rate_req;
			rate_settled     <= (next_rate_cnt == RATE_N - ONE);
		end
	end

	// bus live flag registered in the core domain before it crosses
	logic bus_live;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_live <= 1'b0;
		end else begin
			bus_live <= (next_state != ST_INIT);
		end
	end

	// readback toward the bus domain: three flops for ready and not-ready, two per flag bit, quasi-static data
	logic [1:0]        rdy_m;
	logic [FLAG_W-1:0] fl_m0;
	logic [1:0]        nr_m;
	always_ff @(posedge mgmt_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdy_m                <= 2'h0;
			fl_m0                <= FLAGS_RESET;
			mgmt_flags_rdata     <= FLAGS_RESET;
			nr_m                 <= 2'h3;
			mgmt_bus_ready       <= 1'b0;
			mgmt_not_ready_rdata <= 1'b1;
		end else begin
			rdy_m                <= {rdy_m[0], bus_live};
			fl_m0                <= flags;
			mgmt_flags_rdata     <= fl_m0;
			nr_m                 <= {nr_m[0], not_ready};
			mgmt_bus_ready       <= rdy_m[1];
			mgmt_not_ready_rdata <= nr_m[1];
		end
	end
endmodule : module_mgmt_timing

// ==== test/mgmt_host_model.sv ====
/*
 * host side of the management bus: read and write stop strobes.
 * assumes a free running bus clock from the bench.
 */
`timescale 1ns/100ps
module mgmt_host_model (
	// bus clock
	input  wire logic                          mgmt_clk,
	// decoded transfers
	output logic                               mgmt_read_stop,
	output logic                               mgmt_write_stop,
	output logic [mgmt_timing_pkg::FLAG_W-1:0] mgmt_mask_wdata,
	output logic                               mgmt_pdown_wdata,
	output logic                               mgmt_rate_wdata
);
	import mgmt_timing_pkg::*;
	// idle bus
	initial begin
		mgmt_read_stop = 1'b0;
		mgmt_write_stop = 1'b0;
		mgmt_mask_wdata = 8'h00;
		mgmt_pdown_wdata = 1'b0;
		mgmt_rate_wdata = 1'b0;
	end
	// one stop strobe, then a gap of at least four bus clocks
	task automatic xfer(input logic wr, input logic [FLAG_W-1:0] m,
		input logic pd, input logic rs, input int gap);
		@(posedge mgmt_clk);
		#1;
		mgmt_mask_wdata = m;
		mgmt_pdown_wdata = pd;
		mgmt_rate_wdata = rs;
		mgmt_read_stop = !wr;
		mgmt_write_stop = wr;
		@(posedge mgmt_clk);
		#1;
		mgmt_read_stop = 1'b0;
		mgmt_write_stop = 1'b0;
		repeat (gap) @(posedge mgmt_clk);
	endtask : xfer
endmodule : mgmt_host_model

// ==== test/mgmt_timing_checker.sv ====
/*
 * timing relations at the ports of the management block.
 * assumes the core clock domain; bound into the design top.
 */
`timescale 1ns/100ps
module mgmt_timing_checker #(
	parameter int unsigned INIT_CYC   = 1000,
	parameter int unsigned LP_OFF_CYC = 500
) (
	input wire logic                               clk,
	input wire logic                               reset_n,
	input wire logic                               mgmt_bus_ready,
	input wire logic [mgmt_timing_pkg::FLAG_W-1:0] mgmt_flags_rdata,
	input wire logic                               mgmt_not_ready_rdata,
	input wire logic                               module_reset_pin_active_low,
	input wire logic                               low_power_select_pin,
	input wire logic                               interrupt_request_out_low,
	input wire logic                               power_level1,
	input wire logic                               fully_functional,
	input wire logic                               rate_select,
	input wire logic                               rate_settled
);
	import mgmt_timing_pkg::*;
	localparam int unsigned RLIM = RATE_CYC + 20;
	localparam int WAKE_MAX = int'(LP_OFF_CYC) + 5;
	logic [15:0] cnt, next_cnt, rcnt, next_rcnt;
	logic        prev_rate;
	// cycles since reset release and since a rate change
	always_comb begin
		next_cnt = (cnt == 16'(INIT_CYC + 40)) ? cnt : cnt + 16'h0001;
		if (!module_reset_pin_active_low)
			next_cnt = 16'h0000;
		next_rcnt = (rcnt == 16'(RLIM)) ? rcnt : rcnt + 16'h0001;
		if (rate_select != prev_rate)
			next_rcnt = 16'h0001;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 16'h0000;
			rcnt <= 16'(RLIM);
			prev_rate <= 1'b0;
		end else begin
			cnt <= next_cnt;
			rcnt <= next_rcnt;
			prev_rate <= rate_select;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_irq_has_cause: assert property (
		$fell(interrupt_request_out_low) |-> ##[0:8]
		((|mgmt_flags_rdata) || $fell(mgmt_not_ready_rdata)))
		else $error("interrupt low without cause");
	a_ready_irq_low: assert property (
		$fell(mgmt_not_ready_rdata) |-> ##[0:8] !interrupt_request_out_low)
		else $error("no interrupt at readiness");
	a_init_not_done: assert property (
		cnt != 16'h0000 && cnt < 16'(INIT_CYC - 10) |-> !fully_functional)
		else $error("functional too early");
	a_init_done_time: assert property (
		cnt == 16'(INIT_CYC + 30) |-> fully_functional || power_level1)
		else $error("init not finished");
	a_bus_ready_time: assert property (
		cnt == 16'(INIT_CYC + 30) |-> mgmt_bus_ready)
		else $error("bus not ready");
	a_lp_pin_enter: assert property (
		$rose(low_power_select_pin) |-> ##[1:20] power_level1)
		else $error("low power not entered");
	a_wake_in_time: assert property (
		$fell(power_level1) && mgmt_bus_ready |-> ##[1:WAKE_MAX]
		fully_functional)
		else $error("wake not finished");
	a_lp_excludes_ff: assert property (
		power_level1 |-> !fully_functional)
		else $error("functional in low power");
	a_rate_hold_low: assert property (
		rcnt >= 16'h0002 && rcnt < 16'(RATE_CYC - 10) |-> !rate_settled)
		else $error("rate settled too early");
	a_rate_settle_by: assert property (
		rcnt == 16'(RATE_CYC + 10) |-> rate_settled)
		else $error("rate not settled");
endmodule : mgmt_timing_checker

bind module_mgmt_timing mgmt_timing_checker #(
	.INIT_CYC(INIT_CYC),
	.LP_OFF_CYC(LP_OFF_CYC)
) chk (
	.clk                         (clk),
	.reset_n                     (reset_n),
	.mgmt_bus_ready              (mgmt_bus_ready),
	.mgmt_flags_rdata            (mgmt_flags_rdata),
	.mgmt_not_ready_rdata        (mgmt_not_ready_rdata),
	.module_reset_pin_active_low (module_reset_pin_active_low),
	.low_power_select_pin        (low_power_select_pin),
	.interrupt_request_out_low   (interrupt_request_out_low),
	.power_level1                (power_level1),
	.fully_functional            (fully_functional),
	.rate_select                 (rate_select),
	.rate_settled                (rate_settled)
);

// ==== test/module_mgmt_timing_bench.sv ====
/*
 * self-checking bench for the management timing block.
 * assumes shortened init and wake counts set below.
 */
`timescale 1ns/100ps
module module_mgmt_timing_bench;
	import mgmt_timing_pkg::*;
	localparam int unsigned INIT = 1000;
	localparam int unsigned WAKE = 500;
	logic clk, mgmt_clk, reset_n, mgmt_read_stop, mgmt_write_stop;
	logic mgmt_pdown_wdata, mgmt_rate_wdata, mgmt_bus_ready, rx_loss;
	logic mgmt_not_ready_rdata, module_reset_pin_active_low, tx_fault;
	logic low_power_select_pin, interrupt_request_out_low, power_level1;
	logic fully_functional, rate_select, rate_settled;
	logic [FLAG_W-1:0] mgmt_mask_wdata, mgmt_flags_rdata, other_cond, mask;
	logic [31:0] seed = 32'h53621AD9;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int b;
	module_mgmt_timing #(.INIT_CYC(INIT), .LP_OFF_CYC(WAKE)) DUT (
		.clk                         (clk),
		.reset_n                     (reset_n),
		.mgmt_clk                    (mgmt_clk),
		.mgmt_read_stop              (mgmt_read_stop),
		.mgmt_write_stop             (mgmt_write_stop),
		.mgmt_mask_wdata             (mgmt_mask_wdata),
		.mgmt_pdown_wdata            (mgmt_pdown_wdata),
		.mgmt_rate_wdata             (mgmt_rate_wdata),
		.mgmt_bus_ready              (mgmt_bus_ready),
		.mgmt_flags_rdata            (mgmt_flags_rdata),
		.mgmt_not_ready_rdata        (mgmt_not_ready_rdata),
		.module_reset_pin_active_low (module_reset_pin_active_low),
		.low_power_select_pin        (low_power_select_pin),
		.interrupt_request_out_low   (interrupt_request_out_low),
		.rx_loss                     (rx_loss),
		.tx_fault                    (tx_fault),
		.other_cond                  (other_cond),
		.power_level1                (power_level1),
		.fully_functional            (fully_functional),
		.rate_select                 (rate_select),
		.rate_settled                (rate_settled)
	);
	mgmt_host_model host (
		.mgmt_clk         (mgmt_clk),
		.mgmt_read_stop   (mgmt_read_stop),
		.mgmt_write_stop  (mgmt_write_stop),
		.mgmt_mask_wdata  (mgmt_mask_wdata),
		.mgmt_pdown_wdata (mgmt_pdown_wdata),
		.mgmt_rate_wdata  (mgmt_rate_wdata)
	);
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	// expected pin level from latched flags and mask
	function automatic logic exp_irq(input logic [FLAG_W-1:0] f,
		input logic [FLAG_W-1:0] m);
		return ~|(f & ~m);
	endfunction : exp_irq
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic set_cond(input int k, input logic v);
		@(posedge clk);
		#1;
		if (k == FLAG_LOS) rx_loss = v;
		else if (k == FLAG_TXFAULT) tx_fault = v;
		else other_cond[k] = v;
	endtask : set_cond
	task automatic summarize;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	// clocks, the bus clock unrelated in phase
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		mgmt_clk = 1'b0;
		#3.3;
		forever #7.5 mgmt_clk = ~mgmt_clk;
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		reset_n = 1'b0;
		module_reset_pin_active_low = 1'b1;
		low_power_select_pin = 1'b0;
		{rx_loss, tx_fault, other_cond, mask} = '0;
		tick(10);
		check("irq in reset", 8'h01, interrupt_request_out_low);
		check("not ready in reset", 8'h01, mgmt_not_ready_rdata);
		tick(10);
		reset_n = 1'b1;
		tick(INIT + 50);
		check("functional", 8'h01, fully_functional);
		check("bus ready", 8'h01, mgmt_bus_ready);
		check("not ready", 8'h00, mgmt_not_ready_rdata);
		check("ready irq", 8'h00, interrupt_request_out_low);
		host.xfer(1'b0, mask, 1'b0, 1'b0, 4);
		tick(10);
		check("ready irq off", 8'h01, interrupt_request_out_low);
		// loss, fault, then random conditions optionally masked, raised, latched, then read
		for (int i = 0; i < 8; i++) begin
			seed = xorshift(seed);
			b = (i < 2) ? i : int'(seed[2:0]);
			mask = (i < 4) ? 8'h00 : seed[15:8];
			host.xfer(1'b1, mask, 1'b0, 1'b0, 4 + int'(seed[17:16]));
			set_cond(b, 1'b1);
			tick(6);
			check("flag", 8'h01 << b, mgmt_flags_rdata);
			check("flag irq", {7'h00, exp_irq(8'h01 << b, mask)},
				interrupt_request_out_low);
			set_cond(b, 1'b0);
			tick(6);
			check("flag held", 8'h01 << b, mgmt_flags_rdata);
			host.xfer(1'b1, 8'h00, 1'b0, 1'b0, 4);
			tick(8);
			check("unmask irq", 8'h00, interrupt_request_out_low);
			host.xfer(1'b0, 8'h00, 1'b0, 1'b0, 4);
			tick(10);
			check("flag read", 8'h00, mgmt_flags_rdata);
			check("irq off", 8'h01, interrupt_request_out_low);
		end
		// mask after the flag is up, then a read while the cause stays
		set_cond(FLAG_LOS, 1'b1);
		tick(6);
		host.xfer(1'b1, 8'h01, 1'b0, 1'b0, 4);
		tick(8);
		check("mask after set", 8'h01, interrupt_request_out_low);
		host.xfer(1'b1, 8'h00, 1'b0, 1'b0, 4);
		host.xfer(1'b0, 8'h00, 1'b0, 1'b0, 4);
		tick(10);
		check("set wins read", 8'h01, mgmt_flags_rdata);
		check("set wins irq", 8'h00, interrupt_request_out_low);
		set_cond(FLAG_LOS, 1'b0);
		host.xfer(1'b0, 8'h00, 1'b0, 1'b0, 4);
		tick(10);
		check("los cleared", 8'h00, mgmt_flags_rdata);
		check("los irq off", 8'h01, interrupt_request_out_low);
		host.xfer(1'b1, 8'h00, 1'b0, 1'b1, 4);
		tick(5);
		check("rate", 8'h01, rate_select);
		check("rate settling", 8'h00, rate_settled);
		tick(RATE_CYC + 20);
		check("rate settled", 8'h01, rate_settled);
		host.xfer(1'b1, 8'h00, 1'b1, 1'b1, 5);
		tick(5);
		check("pdown level1", 8'h01, power_level1);
		host.xfer(1'b1, 8'h00, 1'b0, 1'b1, 6);
		tick(WAKE + 20);
		check("pdown wake", 8'h01, fully_functional);
		low_power_select_pin = 1'b1;
		tick(5);
		check("pin level1", 8'h01, power_level1);
		low_power_select_pin = 1'b0;
		tick(WAKE + 20);
		check("pin wake", 8'h01, fully_functional);
		module_reset_pin_active_low = 1'b0;
		tick(300);
		module_reset_pin_active_low = 1'b1;
		tick(20);
		check("pin reset", 8'h00, fully_functional);
		tick(INIT + 50);
		check("reset done", 8'h01, fully_functional);
		summarize();
	end
endmodule : module_mgmt_timing_bench
